/* hdl/bpl_pkg.sv */
package bpl_pkg;

	// ========================================
	// address spaces and transfer kinds
	typedef enum logic [2:0] {
		SP_RSVD,
		SP_SHORT,
		SP_STD,
		SP_EXT,
		SP_USER
	} bpl_space_t;

	typedef enum logic [2:0] {
		K_ADDR_ONLY,
		K_BYTE,
		K_PAIR,
		K_QUAD,
		K_SBYTE_BLK,
		K_DBYTE_BLK,
		K_QUAD_BLK
	} bpl_kind_t;

	// ========================================
	// modifier code maps, one bit per code
	localparam int AM_CODES = 64;
	localparam logic [63:0] AM_SHORT_MAP = 64'h0000_2200_0000_0000;
	localparam logic [63:0] AM_STD_MAP = 64'hee00_0000_0000_0000;
	localparam logic [63:0] AM_EXT_MAP = 64'h0000_0000_0000_ee00;
	localparam logic [63:0] AM_USER_MAP = 64'h0000_0000_ffff_0000;
	localparam logic [63:0] AM_BLK_MAP = 64'h8800_0000_0000_8800;

	// ========================================
	// group compare masks over a[31:2]
	localparam logic [29:0] GRP_MASK_SHORT = 30'h0000_3fff;
	localparam logic [29:0] GRP_MASK_STD = 30'h003f_ffff;
	localparam logic [29:0] GRP_MASK_EXT = 30'h3fff_ffff;
	localparam logic [29:0] GRP_ONE = 30'h0000_0001;

	// ========================================
	// byte lane enables, bit n is byte n
	localparam logic [3:0] LANE_NONE = 4'h0;
	localparam logic [3:0] LANE_ALL = 4'hf;
	localparam logic [3:0] LANE_B0_2 = 4'h7;
	localparam logic [3:0] LANE_B1_3 = 4'he;
	localparam logic [3:0] LANE_B1_2 = 4'h6;
	localparam logic [3:0] LANE_PAIR_LO = 4'h3;
	localparam logic [3:0] LANE_PAIR_HI = 4'hc;
	localparam logic [3:0] LANE_ONE = 4'h1;

	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [1:0] IDX_ONE = 2'h1;
	localparam logic [1:0] IDX_LAST = 2'h3;

endpackage

/* hdl/bpl_bus_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface bpl_bus_if;
	// ========================================
	// lines driven by the master
	logic as_n;
	logic ds0_n;
	logic ds1_n;
	logic lword_n;
	logic write_n;
	logic [31:1] addr;
	logic [5:0] am;
	// ========================================
	// open-drain acknowledge lines from the slave
	logic dtack_o;
	logic dtack_oe;
	logic berr_o;
	logic berr_oe;
	logic dtack_n;
	logic berr_n;

	// wired level: released line floats high through the terminator
	assign dtack_n = ~(dtack_oe & ~dtack_o);
	assign berr_n = ~(berr_oe & ~berr_o);

	modport master (
		output as_n, ds0_n, ds1_n, lword_n, write_n, addr, am,
		input dtack_n, berr_n
	);

	modport slave (
		input as_n, ds0_n, ds1_n, lword_n, write_n, addr, am, dtack_n, berr_n,
		output dtack_o, dtack_oe, berr_o, berr_oe
	);
endinterface

`default_nettype wire

/* hdl/bpl_am_class.sv */
`timescale 1ns/10ps
`default_nettype none

module bpl_am_class (
	// modifier code
	input wire logic [5:0] am,
	// user code handling
	input wire bpl_pkg::bpl_space_t user_space,
	input wire logic user_blk,
	// classification
	output bpl_pkg::bpl_space_t space,
	output logic blk
);
	// ========================================
	// classification
	always_comb begin
		space = bpl_pkg::SP_RSVD;
		blk = bpl_pkg::AM_BLK_MAP[am];
		// defined codes map only to their fixed meaning
		if (bpl_pkg::AM_SHORT_MAP[am]) begin
			space = bpl_pkg::SP_SHORT;
		end else if (bpl_pkg::AM_STD_MAP[am]) begin
			space = bpl_pkg::SP_STD;
		end else if (bpl_pkg::AM_EXT_MAP[am]) begin
			space = bpl_pkg::SP_EXT;
		end else if (bpl_pkg::AM_USER_MAP[am]) begin
			// board picks the meaning; rsvd here means not claimed
			space = user_space;
			blk = user_blk;
		end else begin
			blk = 1'b0;
		end
	end
endmodule

`default_nettype wire

/* hdl/bpl_slave.sv */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - address-only cycle: strobes high, ignore A01/LWORD
// - single-byte block strobes alternate per transfer
// - even start byte: DS1 low first
// - odd start byte: DS0 low first
// - single-byte block: A01 used before first ack
// - A01 low for bytes 0-1, high 2-3
// - double-byte block: both strobes low each transfer
// - double-byte block A01 picks pair, first only
// - six modifier lines, 64 codes in three classes
// - short codes decode group from A02-A15
// - standard codes decode group from A02-A23
// - extended codes decode group from A02-A31
// - reserved codes get no acknowledge, no error
// - user codes get board-configurable meaning
// - group from upper lines, lanes from four
// - master avoids the two illegal lane combos
// - single- and double-byte blocks with LWORD high; quad all low
module bpl_slave (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// backplane
	bpl_bus_if.slave bus,
	// decode configuration
	input wire logic [31:2] win_base,
	input wire bpl_pkg::bpl_space_t user_space,
	input wire logic user_blk,
	// access to local resource
	output logic acc_stb,
	output logic [31:2] acc_grp,
	output logic [3:0] acc_lanes,
	output logic acc_write,
	output logic [5:0] acc_am,
	input wire logic usr_ack,
	input wire logic usr_err,
	// status
	output logic cyc_sel
);
	typedef enum {ST_IDLE, ST_ARM, ST_WAIT, ST_HOLD} bpl_sst_t;

	// ========================================
	// sampled bus lines
	logic as_q, ds0_q, ds1_q, a01_q, lword_q, write_q;
	logic [5:0] am_q;
	logic [31:2] addr_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			as_q <= 1'b1;
			ds0_q <= 1'b1;
			ds1_q <= 1'b1;
			a01_q <= 1'b0;
			lword_q <= 1'b1;
			write_q <= 1'b1;
			am_q <= 6'h00;
			addr_q <= 30'h0000_0000;
		end else begin
			as_q <= bus.as_n;
			ds0_q <= bus.ds0_n;
			ds1_q <= bus.ds1_n;
			a01_q <= bus.addr[1];
			lword_q <= bus.lword_n;
			write_q <= bus.write_n;
			am_q <= bus.am;
			addr_q <= bus.addr[31:2];
		end
	end

	// ========================================
	// modifier decode
	bpl_pkg::bpl_space_t space;
	logic am_blk;
	logic [29:0] grp_mask;
	logic hit;

	bpl_am_class bpl_am_class_inst (
		.am(am_q),
		.user_space(user_space),
		.user_blk(user_blk),
		.space(space),
		.blk(am_blk)
	);

	always_comb begin
		case (space)
			bpl_pkg::SP_SHORT: grp_mask = bpl_pkg::GRP_MASK_SHORT;
			bpl_pkg::SP_STD: grp_mask = bpl_pkg::GRP_MASK_STD;
			bpl_pkg::SP_EXT: grp_mask = bpl_pkg::GRP_MASK_EXT;
			default: grp_mask = bpl_pkg::GRP_MASK_EXT;
		endcase
		// upper lines outside the space are never compared
		hit = (((addr_q ^ win_base) & grp_mask) == 30'h0000_0000)
			&& (space != bpl_pkg::SP_RSVD);
	end

	// ========================================
	// cycle state
	bpl_sst_t st_q, st_d;
	logic sel_q, sel_d, blk_q, blk_d, first_q, first_d;
	logic ack_q, ack_d, err_q, err_d, stb_q, stb_d;
	logic [1:0] idx_q, idx_d;
	logic [29:0] grp_q, grp_d, grp_mask_q, grp_mask_d;
	logic [29:0] out_grp_q, out_grp_d;
	logic [3:0] lanes_q, lanes_d;
	logic wr_q, wr_d;
	logic [5:0] oam_q, oam_d;
	logic strobe, released;
	logic [1:0] cur_idx;
	logic [29:0] cur_grp;
	logic [3:0] cur_lanes;

	// lane and pointer for the transfer now on the strobes
	always_comb begin
		strobe = ~ds0_q | ~ds1_q;
		released = ds0_q & ds1_q;
		cur_grp = first_q ? (addr_q & grp_mask_q) : grp_q;
		cur_idx = idx_q;
		cur_lanes = bpl_pkg::LANE_NONE;
		if (blk_q && !lword_q) begin
			cur_idx = 2'h0;
			cur_lanes = bpl_pkg::LANE_ALL;
		end else if (blk_q && !(ds0_q ^ ds1_q)) begin
			// pair index held in bit 1; A01 only counts on the first
			if (first_q) begin
				cur_idx = {a01_q, 1'b0};
			end
			cur_lanes = cur_idx[1] ? bpl_pkg::LANE_PAIR_HI : bpl_pkg::LANE_PAIR_LO;
		end else if (blk_q) begin
			// after the first ack A01 and the strobe choice are not trusted
			if (first_q) begin
				cur_idx = {a01_q, ds1_q};
			end
			cur_lanes = bpl_pkg::LANE_ONE << cur_idx;
		end else if (lword_q) begin
			cur_idx = {a01_q, ds1_q};
			if (ds0_q ^ ds1_q) begin
				cur_lanes = bpl_pkg::LANE_ONE << cur_idx;
			end else begin
				cur_lanes = a01_q ? bpl_pkg::LANE_PAIR_HI : bpl_pkg::LANE_PAIR_LO;
			end
		end else begin
			// illegal combos decode as bytes 1-2, which keeps the logic small
			case ({ds1_q, ds0_q, a01_q})
				3'b000: cur_lanes = bpl_pkg::LANE_ALL;
				3'b010: cur_lanes = bpl_pkg::LANE_B0_2;
				3'b100: cur_lanes = bpl_pkg::LANE_B1_3;
				default: cur_lanes = bpl_pkg::LANE_B1_2;
			endcase
		end
	end

	always_comb begin
		st_d = st_q;
		sel_d = sel_q;
		blk_d = blk_q;
		first_d = first_q;
		ack_d = ack_q;
		err_d = err_q;
		stb_d = 1'b0;
		idx_d = idx_q;
		grp_d = grp_q;
		grp_mask_d = grp_mask_q;
		out_grp_d = out_grp_q;
		lanes_d = lanes_q;
		wr_d = wr_q;
		oam_d = oam_q;
		case (st_q)
			ST_IDLE: begin
				if (!as_q) begin
					sel_d = hit;
					blk_d = am_blk;
					grp_mask_d = grp_mask;
					first_d = 1'b1;
					st_d = ST_ARM;
				end
			end
			ST_ARM: begin
				if (as_q) begin
					sel_d = 1'b0;
					st_d = ST_IDLE;
				end else if (strobe && sel_q) begin
					idx_d = cur_idx;
					grp_d = cur_grp;
					out_grp_d = cur_grp;
					lanes_d = cur_lanes;
					wr_d = ~write_q;
					oam_d = am_q;
					stb_d = 1'b1;
					st_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (as_q) begin
					sel_d = 1'b0;
					st_d = ST_IDLE;
				end else if (usr_err) begin
					err_d = 1'b1;
					st_d = ST_HOLD;
				end else if (usr_ack) begin
					ack_d = 1'b1;
					st_d = ST_HOLD;
					if (blk_q && !lword_q) begin
						grp_d = grp_q + bpl_pkg::GRP_ONE;
					end else if (blk_q && !(ds0_q ^ ds1_q)) begin
						idx_d = idx_q ^ 2'h2;
						if (idx_q[1]) begin
							grp_d = grp_q + bpl_pkg::GRP_ONE;
						end
					end else if (blk_q) begin
						idx_d = idx_q + bpl_pkg::IDX_ONE;
						if (idx_q == bpl_pkg::IDX_LAST) begin
							grp_d = grp_q + bpl_pkg::GRP_ONE;
						end
					end
				end
			end
			ST_HOLD: begin
				// hold the acknowledge until the master lets both strobes go
				if (released) begin
					ack_d = 1'b0;
					err_d = 1'b0;
					first_d = 1'b0;
					st_d = ST_ARM;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= ST_IDLE;
			sel_q <= 1'b0;
			blk_q <= 1'b0;
			first_q <= 1'b1;
			ack_q <= 1'b0;
			err_q <= 1'b0;
			stb_q <= 1'b0;
			idx_q <= 2'h0;
			grp_q <= 30'h0000_0000;
			grp_mask_q <= bpl_pkg::GRP_MASK_EXT;
			out_grp_q <= 30'h0000_0000;
			lanes_q <= bpl_pkg::LANE_NONE;
			wr_q <= 1'b0;
			oam_q <= 6'h00;
		end else begin
			st_q <= st_d;
			sel_q <= sel_d;
			blk_q <= blk_d;
			first_q <= first_d;
			ack_q <= ack_d;
			err_q <= err_d;
			stb_q <= stb_d;
			idx_q <= idx_d;
			grp_q <= grp_d;
			grp_mask_q <= grp_mask_d;
			out_grp_q <= out_grp_d;
			lanes_q <= lanes_d;
			wr_q <= wr_d;
			oam_q <= oam_d;
		end
	end

	// ========================================
	// outputs
	assign bus.dtack_o = 1'b0;
	assign bus.dtack_oe = ack_q;
	assign bus.berr_o = 1'b0;
	assign bus.berr_oe = err_q;
	assign acc_stb = stb_q;
	assign acc_grp = out_grp_q;
	assign acc_lanes = lanes_q;
	assign acc_write = wr_q;
	assign acc_am = oam_q;
	assign cyc_sel = sel_q;
endmodule

`default_nettype wire

/* hdl/bpl_master.sv */
`timescale 1ns/10ps
`default_nettype none

module bpl_master (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// backplane
	bpl_bus_if.master bus,
	// request
	input wire logic go,
	input wire bpl_pkg::bpl_kind_t kind,
	input wire logic [31:1] addr,
	input wire logic [5:0] am,
	input wire logic write,
	input wire logic [7:0] count,
	// status
	output logic busy,
	output logic done,
	output logic err
);
	typedef enum {M_IDLE, M_ADDR, M_STRB, M_REL, M_END} bpl_mst_t;

	bpl_mst_t st_q, st_d;
	bpl_pkg::bpl_kind_t kind_q, kind_d;
	logic as_q, as_d, ds0_q, ds0_d, ds1_q, ds1_d, lw_q, lw_d, wr_q, wr_d;
	logic [31:1] a_q, a_d;
	logic [5:0] am_q, am_d;
	logic [7:0] left_q, left_d;
	logic alt_q, alt_d, err_q, err_d, done_q, done_d, ack_s_q, berr_s_q;

	// ========================================
	// strobe pattern for the next transfer
	function automatic logic [1:0] strobes(input bpl_pkg::bpl_kind_t k, input logic even_next);
		// {ds1_n, ds0_n}; only quad kinds drop LWORD, so both strobes fall then
		case (k)
			bpl_pkg::K_BYTE: strobes = even_next ? 2'b01 : 2'b10;
			bpl_pkg::K_SBYTE_BLK: strobes = even_next ? 2'b01 : 2'b10;
			bpl_pkg::K_ADDR_ONLY: strobes = 2'b11;
			default: strobes = 2'b00;
		endcase
	endfunction

	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		as_d = as_q;
		ds0_d = ds0_q;
		ds1_d = ds1_q;
		lw_d = lw_q;
		wr_d = wr_q;
		a_d = a_q;
		am_d = am_q;
		left_d = left_q;
		alt_d = alt_q;
		err_d = err_q;
		done_d = 1'b0;
		case (st_q)
			M_IDLE: begin
				if (go) begin
					kind_d = kind;
					a_d = addr;
					am_d = am;
					wr_d = ~write;
					alt_d = ~addr[1];
					lw_d = ~((kind == bpl_pkg::K_QUAD) || (kind == bpl_pkg::K_QUAD_BLK));
					if ((kind == bpl_pkg::K_QUAD) || (kind == bpl_pkg::K_QUAD_BLK)) begin
						a_d[1] = 1'b0;
					end
					if ((kind == bpl_pkg::K_SBYTE_BLK) || (kind == bpl_pkg::K_BYTE)) begin
						alt_d = ~addr[1];
					end
					left_d = (count == 8'h00) ? bpl_pkg::CNT_ONE : count;
					if (kind != bpl_pkg::K_SBYTE_BLK && kind != bpl_pkg::K_DBYTE_BLK
						&& kind != bpl_pkg::K_QUAD_BLK) begin
						left_d = bpl_pkg::CNT_ONE;
					end
					err_d = 1'b0;
					as_d = 1'b0;
					st_d = M_ADDR;
				end
			end
			M_ADDR: begin
				if (kind_q == bpl_pkg::K_ADDR_ONLY) begin
					st_d = M_END;
				end else begin
					{ds1_d, ds0_d} = strobes(kind_q, alt_q ^ a_q[1]);
					st_d = M_STRB;
				end
			end
			M_STRB: begin
				if (ack_s_q) begin
					ds0_d = 1'b1;
					ds1_d = 1'b1;
					err_d = berr_s_q;
					left_d = left_q - bpl_pkg::CNT_ONE;
					alt_d = ~alt_q;
					st_d = M_REL;
				end
			end
			M_REL: begin
				// next strobe waits until the slave lets its acknowledge go
				if (!ack_s_q) begin
					if (err_q || left_q == 8'h00) begin
						st_d = M_END;
					end else begin
						{ds1_d, ds0_d} = strobes(kind_q, alt_q ^ a_q[1]);
						st_d = M_STRB;
					end
				end
			end
			M_END: begin
				as_d = 1'b1;
				done_d = 1'b1;
				st_d = M_IDLE;
			end
			default: begin
				st_d = M_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= M_IDLE;
			kind_q <= bpl_pkg::K_ADDR_ONLY;
			as_q <= 1'b1;
			ds0_q <= 1'b1;
			ds1_q <= 1'b1;
			lw_q <= 1'b1;
			wr_q <= 1'b1;
			a_q <= 31'h0000_0000;
			am_q <= 6'h00;
			left_q <= 8'h00;
			alt_q <= 1'b0;
			err_q <= 1'b0;
			done_q <= 1'b0;
			ack_s_q <= 1'b0;
			berr_s_q <= 1'b0;
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			as_q <= as_d;
			ds0_q <= ds0_d;
			ds1_q <= ds1_d;
			lw_q <= lw_d;
			wr_q <= wr_d;
			a_q <= a_d;
			am_q <= am_d;
			left_q <= left_d;
			alt_q <= alt_d;
			err_q <= err_d;
			done_q <= done_d;
			ack_s_q <= ~bus.dtack_n | ~bus.berr_n;
			berr_s_q <= ~bus.berr_n;
		end
	end

	// ========================================
	// outputs
	assign bus.as_n = as_q;
	assign bus.ds0_n = ds0_q;
	assign bus.ds1_n = ds1_q;
	assign bus.lword_n = lw_q;
	assign bus.write_n = wr_q;
	assign bus.addr = a_q;
	assign bus.am = am_q;
	assign busy = (st_q != M_IDLE);
	assign done = done_q;
	assign err = err_q;
endmodule

`default_nettype wire

/* bench/bpl_properties.sv */
`timescale 1ns/10ps
`default_nettype none

module bpl_properties (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// master lines
	input wire logic as_n,
	input wire logic ds0_n,
	input wire logic ds1_n,
	input wire logic lword_n,
	input wire logic write_n,
	input wire logic [31:1] addr,
	input wire logic [5:0] am,
	// slave lines
	input wire logic dtack_o,
	input wire logic dtack_oe,
	input wire logic berr_o,
	input wire logic berr_oe,
	input wire logic dtack_n,
	input wire logic berr_n
);
	// ========================================
	// helpers
	logic [63:0] def_map;
	logic rsvd;
	logic ds_idle;
	assign def_map = bpl_pkg::AM_SHORT_MAP | bpl_pkg::AM_STD_MAP | bpl_pkg::AM_EXT_MAP
		| bpl_pkg::AM_USER_MAP;
	assign rsvd = ~def_map[am];
	assign ds_idle = ds0_n & ds1_n;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	// ========================================
	// wire rules
	rsvd_quiet_a: assert property (!as_n && rsvd |-> !dtack_oe && !berr_oe)
		else $error("answer on a reserved code");
	ack_on_strobe_a: assert property ($rose(dtack_oe) || $rose(berr_oe) |->
		$past(!ds_idle) && !as_n) else $error("answer without a strobe");
	ack_release_a: assert property (ds_idle [*3] |-> !dtack_oe && !berr_oe)
		else $error("answer held with strobes high");
	ack_excl_a: assert property (!(dtack_oe && berr_oe))
		else $error("acknowledge and error together");
	drive_low_a: assert property (dtack_oe |-> !dtack_o && !dtack_n)
		else $error("acknowledge line not pulled low");
	lane_legal_a: assert property (!as_n |-> !(!lword_n && addr[1] && (ds0_n != ds1_n)))
		else $error("illegal lane combination");
	addr_hold_a: assert property (!as_n && !$past(as_n) |-> $stable(addr) && $stable(am)
		&& $stable(lword_n) && $stable(write_n)) else $error("address moved in cycle");
	strobe_in_as_a: assert property (!ds_idle |-> !as_n)
		else $error("strobe outside address cycle");
	strobe_drop_a: assert property ($fell(dtack_n) || $fell(berr_n) |-> ##[1:3] ds_idle)
		else $error("strobes not released after answer");
endmodule

`default_nettype wire

/* bench/backplane_byte_lane_and_am_decode_test.sv */
`timescale 1ns/10ps
`default_nettype none

module backplane_byte_lane_and_am_decode_test;
	// ========================================
	// signals
	logic ref_clk;
	logic srst;
	logic go;
	bpl_pkg::bpl_kind_t kind;
	logic [31:1] maddr;
	logic [5:0] mam;
	logic write;
	logic [7:0] count;
	logic busy;
	logic done;
	logic err;
	logic [31:2] win_base;
	bpl_pkg::bpl_space_t user_space;
	logic user_blk;
	logic usr_ack;
	logic usr_err;
	logic acc_stb;
	logic [31:2] acc_grp;
	logic [3:0] acc_lanes;
	logic acc_write;
	logic [5:0] acc_am;
	logic cyc_sel;
	logic [3:0] lq[$];
	logic [29:0] gq[$];
	logic [1:0] sq[$];
	logic [1:0] ds_q;
	logic acked;
	int miscompares;
	int checks;
	localparam logic [29:0] win = 30'h1234_5678;
	localparam logic [29:0] ws = win & bpl_pkg::GRP_MASK_STD;

	bpl_bus_if bus();
	bpl_master bpl_master_inst (.ref_clk(ref_clk), .srst(srst), .bus(bus.master), .go(go),
		.kind(kind), .addr(maddr), .am(mam), .write(write), .count(count), .busy(busy),
		.done(done), .err(err));
	bpl_slave bpl_slave_inst (.ref_clk(ref_clk), .srst(srst), .bus(bus.slave),
		.win_base(win_base), .user_space(user_space), .user_blk(user_blk), .acc_stb(acc_stb),
		.acc_grp(acc_grp), .acc_lanes(acc_lanes), .acc_write(acc_write), .acc_am(acc_am),
		.usr_ack(usr_ack), .usr_err(usr_err), .cyc_sel(cyc_sel));
	bpl_properties bpl_properties_inst (.ref_clk(ref_clk), .srst(srst), .as_n(bus.as_n),
		.ds0_n(bus.ds0_n), .ds1_n(bus.ds1_n), .lword_n(bus.lword_n), .write_n(bus.write_n),
		.addr(bus.addr), .am(bus.am), .dtack_o(bus.dtack_o), .dtack_oe(bus.dtack_oe),
		.berr_o(bus.berr_o), .berr_oe(bus.berr_oe), .dtack_n(bus.dtack_n), .berr_n(bus.berr_n));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// ========================================
	// monitor, mid-cycle so flops have settled
	always @(negedge ref_clk) begin
		if (acc_stb === 1'b1) begin
			lq.push_back(acc_lanes);
			gq.push_back(acc_grp);
		end
		if (ds_q == 2'h3 && {bus.ds1_n, bus.ds0_n} != 2'h3)
			sq.push_back({bus.ds1_n, bus.ds0_n});
		ds_q = {bus.ds1_n, bus.ds0_n};
		if (bus.dtack_n === 1'b0 || bus.berr_n === 1'b0)
			acked = 1'b1;
	end

	// ========================================
	// shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic do_reset();
		@(negedge ref_clk);
		srst = 1'b1;
		repeat (20) @(negedge ref_clk);
		srst = 1'b0;
	endtask

	// no timeout in the master, so a refused cycle is cut short by a bounded wait
	task automatic run(input bpl_pkg::bpl_kind_t k, input logic [31:1] a, input logic [5:0] m,
		input logic [7:0] n, output logic fin);
		lq.delete();
		gq.delete();
		sq.delete();
		acked = 1'b0;
		fin = 1'b0;
		@(negedge ref_clk);
		kind = k;
		maddr = a;
		mam = m;
		count = n;
		go = 1'b1;
		@(negedge ref_clk);
		go = 1'b0;
		for (int i = 0; i < 300 && !fin; i++) begin
			@(posedge ref_clk);
			#1;
			fin = (done === 1'b1);
		end
	endtask

	task automatic one(input bpl_pkg::bpl_kind_t k, input logic [29:0] g, input logic a1,
		input logic [5:0] m, input logic [3:0] ln, input logic [1:0] st, input logic [29:0] eg);
		logic fin;
		run(k, {g, a1}, m, 8'h00, fin);
		check("done", fin, 1'b1);
		check("busy", busy, 1'b0);
		check("sel", cyc_sel, 1'b1);
		check("stb count", 32'(lq.size()), 1);
		check("lanes", lq[0], ln);
		check("strobes", sq[0], st);
		check("group", gq[0], eg);
		check("ack", acked, 1'b1);
		check("write", acc_write, write);
		check("am", acc_am, m);
	endtask

	task automatic refused(input logic [29:0] g, input logic [5:0] m);
		logic fin;
		run(bpl_pkg::K_BYTE, {g, 1'b0}, m, 8'h00, fin);
		check("refused done", fin, 1'b0);
		check("refused stb", 32'(lq.size()), 0);
		check("refused ack", acked, 1'b0);
		check("refused sel", cyc_sel, 1'b0);
		check("refused busy", busy, 1'b1);
		do_reset();
	endtask

	// ========================================
	// scenarios
	task automatic t_plain();
		one(bpl_pkg::K_BYTE, win, 1'b0, 6'h39, 4'h1, 2'h1, ws);
		write = 1'b1;
		one(bpl_pkg::K_BYTE, win, 1'b1, 6'h39, 4'h4, 2'h1, ws);
		one(bpl_pkg::K_PAIR, win, 1'b0, 6'h39, 4'h3, 2'h0, ws);
		write = 1'b0;
		one(bpl_pkg::K_PAIR, win, 1'b1, 6'h39, 4'hc, 2'h0, ws);
		one(bpl_pkg::K_QUAD, win, 1'b0, 6'h39, 4'hf, 2'h0, ws);
		$display("t_plain finished");
	endtask

	task automatic t_space();
		one(bpl_pkg::K_BYTE, win ^ 30'h0000_4000, 1'b0, 6'h29, 4'h1, 2'h1,
			win & bpl_pkg::GRP_MASK_SHORT);
		one(bpl_pkg::K_BYTE, win ^ 30'h0040_0000, 1'b0, 6'h39, 4'h1, 2'h1, ws);
		one(bpl_pkg::K_BYTE, win, 1'b0, 6'h09, 4'h1, 2'h1, win);
		refused(win ^ 30'h2000_0000, 6'h09);
		refused(win, 6'h00);
		refused(win, 6'h10);
		@(negedge ref_clk);
		user_space = bpl_pkg::SP_STD;
		one(bpl_pkg::K_BYTE, win, 1'b1, 6'h10, 4'h4, 2'h1, ws);
		user_space = bpl_pkg::SP_RSVD;
		$display("t_space finished");
	endtask

	task automatic t_addr_only();
		logic fin;
		for (int b = 0; b < 2; b++) begin
			run(bpl_pkg::K_ADDR_ONLY, {win, b[0]}, 6'h39, 8'h00, fin);
			check("addr only done", fin, 1'b1);
			check("addr only stb", 32'(lq.size() + sq.size()), 0);
			check("addr only ack", acked, 1'b0);
		end
		$display("t_addr_only finished");
	endtask

	task automatic t_blocks();
		logic fin;
		run(bpl_pkg::K_SBYTE_BLK, {win, 1'b1}, 6'h3b, 8'h05, fin);
		check("sblk done", fin, 1'b1);
		check("sblk count", 32'(lq.size()), 5);
		for (int i = 0; i < 5; i++) begin
			check("sblk lanes", lq[i], 4'h1 << ((i + 2) % 4));
			check("sblk strobe", sq[i], (i % 2) ? 2'h2 : 2'h1);
			check("sblk group", gq[i], ws + 30'(i > 1));
		end
		run(bpl_pkg::K_DBYTE_BLK, {win, 1'b1}, 6'h3f, 8'h04, fin);
		check("dblk done", fin, 1'b1);
		check("dblk count", 32'(lq.size() + sq.size()), 8);
		for (int i = 0; i < 4; i++) begin
			check("dblk lanes", lq[i], (i % 2) ? 4'h3 : 4'hc);
			check("dblk strobe", sq[i], 2'h0);
			check("dblk group", gq[i], ws + 30'((i + 1) / 2));
		end
		$display("t_blocks finished");
	endtask

	task automatic t_error();
		logic fin;
		@(negedge ref_clk);
		usr_err = 1'b1;
		run(bpl_pkg::K_BYTE, {win, 1'b0}, 6'h39, 8'h00, fin);
		check("err done", fin, 1'b1);
		check("err flag", err, 1'b1);
		usr_err = 1'b0;
		one(bpl_pkg::K_BYTE, win, 1'b0, 6'h39, 4'h1, 2'h1, ws);
		check("err cleared", err, 1'b0);
		$display("t_error finished");
	endtask

	// ========================================
	// main sequence and watchdog
	initial begin
		miscompares = 0;
		checks = 0;
		srst = 1'b1;
		go = 1'b0;
		kind = bpl_pkg::K_ADDR_ONLY;
		maddr = '0;
		mam = '0;
		write = 1'b0;
		count = '0;
		win_base = win;
		user_space = bpl_pkg::SP_RSVD;
		user_blk = 1'b0;
		usr_ack = 1'b1;
		usr_err = 1'b0;
		ds_q = 2'h3;
		acked = 1'b0;
		repeat (20) @(negedge ref_clk);
		srst = 1'b0;
		t_plain();
		t_space();
		t_addr_only();
		t_blocks();
		t_error();
		summarize();
	end

	initial begin
		#600000;
		miscompares++;
		summarize();
	end
endmodule

`default_nettype wire
